//--- rtl/i2cm_defines.svh
/*
  Offsets, field positions, reset values and timing counts of the two-wire
  master sequence controller. Assumes a 100 MHz ref_clk.
*/
// Functional notes
// - ack polarity 1 sends not-acknowledge, 0 sends acknowledge on receive
// - ack request runs an acknowledge bit; hardware clears it when done
// - receive request clocks in one byte; cleared after the eighth bit
// - stop request generates a Stop; cleared when the stop ends
// - repeated-start request generates a Repeated Start; cleared at its end
// - start request generates a Start; cleared at its end, 0 means idle
// - collision during a master operation sets the collision flag, else 0
// - start-detected flag set on Start or Repeated Start, cleared on Stop
`ifndef I2CM_DEFINES_SVH
`define I2CM_DEFINES_SVH

// ----------------------------------------------------------------
// register offsets (word index)
// ----------------------------------------------------------------
`define I2CM_OFS_CONTROL 3'h0
`define I2CM_OFS_STATUS 3'h1
`define I2CM_OFS_TXDATA 3'h2
`define I2CM_OFS_RXDATA 3'h3
`define I2CM_OFS_IRQ_STAT 3'h4
`define I2CM_OFS_IRQ_MASK 3'h5

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define I2CM_CTL_START 0
`define I2CM_CTL_RSTART 1
`define I2CM_CTL_STOP 2
`define I2CM_CTL_RECV 3
`define I2CM_CTL_ACKSEQ 4
`define I2CM_CTL_ACKPOL 5

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define I2CM_ST_ACKRX 15
`define I2CM_ST_TXBUSY 14
`define I2CM_ST_COLL 10
`define I2CM_ST_STOPSEEN 4
`define I2CM_ST_STARTSEEN 3

// ----------------------------------------------------------------
// interrupt fields and reset values
// ----------------------------------------------------------------
`define I2CM_IRQ_SEQDONE 0
`define I2CM_IRQ_RXBYTE 1
`define I2CM_IRQ_COLL 2
`define I2CM_IRQ_START 3
`define I2CM_IRQ_STOP 4
`define I2CM_IRQ_W 5
`define I2CM_RST_WORD 16'h0000

// ----------------------------------------------------------------
// timing: quarter of a 100 kHz bit period
// ----------------------------------------------------------------
`define I2CM_CLK_PERIOD_NS 10
`define I2CM_QUARTER_NS 2500
`define I2CM_QUARTER_CYC (`I2CM_QUARTER_NS / `I2CM_CLK_PERIOD_NS)

`endif

//--- rtl/i2cm_pkg.sv
/*
  Types of the two-wire master sequence controller.
  Assumes i2cm_defines.svh supplies the numbers.
*/
package i2cm_pkg;

  // ----------------------------------------------------------------
  // sequence engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0]
  {
    I2CM_IDLE,
    I2CM_START,
    I2CM_RSTART,
    I2CM_STOP,
    I2CM_RECV,
    I2CM_ACKSEQ,
    I2CM_XMIT
  } i2cm_state_e;

endpackage

//--- rtl/i2cm_seq.sv
/*
  Master sequence controller of a two-wire serial port: register port,
  Start/Repeated Start/Stop/receive/acknowledge/transmit engine, bus
  monitor and interrupt. Assumes open-drain pads outside with pull-ups;
  pad inputs are asynchronous to ref_clk.
*/
// The implementer's own choices: the register offsets and the address-and-strobe port.
`include "i2cm_defines.svh"

module i2cm_seq #(
  parameter int QUARTER_CYC = `I2CM_QUARTER_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // interrupt
  output logic irq,
  // serial clock line, open drain
  input wire logic serial_clock_line_in,
  output logic serial_clock_line_out,
  output logic serial_clock_line_oe_n,
  // serial data line, open drain
  input wire logic serial_data_line_in,
  output logic serial_data_line_out,
  output logic serial_data_line_oe_n
);

  generate
    if (QUARTER_CYC < 4 || QUARTER_CYC > 65535)
    begin : g_chk
      $error("QUARTER_CYC out of range");
    end
  endgenerate

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  localparam logic [15:0] QLAST = 16'(QUARTER_CYC - 1);

  i2cm_pkg::i2cm_state_e state_reg;
  logic [15:0] cnt_reg;
  logic [1:0] q_reg;
  logic [3:0] bit_reg;
  logic [7:0] shift_reg;
  logic [7:0] rx_data_reg;
  logic [5:0] ctrl_reg;
  logic tx_pend_reg;
  logic ack_rx_reg;
  logic coll_reg;
  logic start_seen_reg;
  logic stop_seen_reg;
  logic [`I2CM_IRQ_W-1:0] irq_stat_reg;
  logic [`I2CM_IRQ_W-1:0] irq_mask_reg;
  logic scl_lo_reg;
  logic sda_lo_reg;
  logic scl_s1_reg, scl_s2_reg, scl_s3_reg;
  logic sda_s1_reg, sda_s2_reg, sda_s3_reg;
  logic tick, last, seq_done, rx_done, coll_hit;
  logic scl_lo_next, sda_lo_next;
  logic bus_start, bus_stop;
  logic [5:0] req_clear;
  logic [`I2CM_IRQ_W-1:0] irq_set;

  // ----------------------------------------------------------------
  // pad synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_s1_reg <= 1'b1;
      scl_s2_reg <= 1'b1;
      scl_s3_reg <= 1'b1;
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
      sda_s3_reg <= 1'b1;
    end
    else
    begin
      scl_s1_reg <= serial_clock_line_in;
      scl_s2_reg <= scl_s1_reg;
      scl_s3_reg <= scl_s2_reg;
      sda_s1_reg <= serial_data_line_in;
      sda_s2_reg <= sda_s1_reg;
      sda_s3_reg <= sda_s2_reg;
    end
  end

  // data edges while the clock line is high mark bus conditions
  assign bus_start = scl_s2_reg && scl_s3_reg && sda_s3_reg && !sda_s2_reg;
  assign bus_stop = scl_s2_reg && scl_s3_reg && !sda_s3_reg && sda_s2_reg;

  // ----------------------------------------------------------------
  // quarter-bit timing
  // ----------------------------------------------------------------
  assign tick = (state_reg != i2cm_pkg::I2CM_IDLE) && (cnt_reg == QLAST);
  assign last = tick && (q_reg == 2'h3);

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cnt_reg <= 16'h0000;
      q_reg <= 2'h0;
    end
    else if (state_reg == i2cm_pkg::I2CM_IDLE || coll_hit)
    begin
      cnt_reg <= 16'h0000;
      q_reg <= 2'h0;
    end
    else if (tick)
    begin
      cnt_reg <= 16'h0000;
      q_reg <= q_reg + 2'h1;
    end
    else
    begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // line drive per state and quarter (1 = pull low)
  // ----------------------------------------------------------------
  always_comb
  begin
    scl_lo_next = 1'b0;
    sda_lo_next = 1'b0;
    case (state_reg)
      i2cm_pkg::I2CM_START:
      begin
        sda_lo_next = (q_reg != 2'h0);
        scl_lo_next = (q_reg == 2'h3);
      end
      i2cm_pkg::I2CM_RSTART:
      begin
        sda_lo_next = q_reg[1];
        scl_lo_next = (q_reg == 2'h0) || (q_reg == 2'h3);
      end
      i2cm_pkg::I2CM_STOP:
      begin
        sda_lo_next = !q_reg[1];
        scl_lo_next = (q_reg == 2'h0);
      end
      i2cm_pkg::I2CM_RECV:
      begin
        scl_lo_next = (q_reg == 2'h0) || (q_reg == 2'h3);
      end
      i2cm_pkg::I2CM_ACKSEQ:
      begin
        sda_lo_next = !ctrl_reg[`I2CM_CTL_ACKPOL];
        scl_lo_next = (q_reg == 2'h0) || (q_reg == 2'h3);
      end
      i2cm_pkg::I2CM_XMIT:
      begin
        sda_lo_next = !bit_reg[3] && !shift_reg[7];
        scl_lo_next = (q_reg == 2'h0) || (q_reg == 2'h3);
      end
      default:
      begin
        scl_lo_next = 1'b0;
        sda_lo_next = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_lo_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
    end
    else if (coll_hit)
    begin
      scl_lo_reg <= 1'b0;
      sda_lo_reg <= 1'b0;
    end
    // idle keeps the lines where the last sequence left them; releasing
    // them here would fake a clock pulse or a stop between sequences
    else if (state_reg != i2cm_pkg::I2CM_IDLE)
    begin
      scl_lo_reg <= scl_lo_next;
      sda_lo_reg <= sda_lo_next;
    end
  end

  assign serial_clock_line_out = 1'b0;
  assign serial_data_line_out = 1'b0;
  assign serial_clock_line_oe_n = !scl_lo_reg;
  assign serial_data_line_oe_n = !sda_lo_reg;

  // ----------------------------------------------------------------
  // collision: a released data line read low at the end of a quarter
  // ----------------------------------------------------------------
  // only checked where this master alone owns the high level; the
  // receive and ack-listen slots legitimately see the target pull low
  always_comb
  begin
    coll_hit = 1'b0;
    if (tick && !sda_lo_reg && !sda_s2_reg)
    begin
      case (state_reg)
        i2cm_pkg::I2CM_START: coll_hit = (q_reg == 2'h0);
        i2cm_pkg::I2CM_RSTART: coll_hit = (q_reg == 2'h1);
        i2cm_pkg::I2CM_STOP: coll_hit = (q_reg == 2'h3);
        i2cm_pkg::I2CM_XMIT: coll_hit = !bit_reg[3] && (q_reg == 2'h2);
        default: coll_hit = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sequence engine
  // ----------------------------------------------------------------
  assign rx_done = last && (state_reg == i2cm_pkg::I2CM_RECV) && (bit_reg == 4'h7);
  always_comb
  begin
    case (state_reg)
      i2cm_pkg::I2CM_RECV: seq_done = rx_done;
      i2cm_pkg::I2CM_XMIT: seq_done = last && (bit_reg == 4'h8);
      i2cm_pkg::I2CM_IDLE: seq_done = 1'b0;
      default: seq_done = last;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_reg <= i2cm_pkg::I2CM_IDLE;
      bit_reg <= 4'h0;
    end
    else if (state_reg == i2cm_pkg::I2CM_IDLE)
    begin
      bit_reg <= 4'h0;
      if (ctrl_reg[`I2CM_CTL_START])
        state_reg <= i2cm_pkg::I2CM_START;
      else if (ctrl_reg[`I2CM_CTL_RSTART])
        state_reg <= i2cm_pkg::I2CM_RSTART;
      else if (ctrl_reg[`I2CM_CTL_STOP])
        state_reg <= i2cm_pkg::I2CM_STOP;
      else if (ctrl_reg[`I2CM_CTL_RECV])
        state_reg <= i2cm_pkg::I2CM_RECV;
      else if (ctrl_reg[`I2CM_CTL_ACKSEQ])
        state_reg <= i2cm_pkg::I2CM_ACKSEQ;
      else if (tx_pend_reg)
        state_reg <= i2cm_pkg::I2CM_XMIT;
    end
    else if (coll_hit || seq_done)
    begin
      state_reg <= i2cm_pkg::I2CM_IDLE;
    end
    else if (last)
    begin
      bit_reg <= bit_reg + 4'h1;
    end
  end

  // shift register: loaded by a data write, sampled at the end of clock-high
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      shift_reg <= 8'h00;
    else if (reg_wr && reg_addr == `I2CM_OFS_TXDATA && state_reg == i2cm_pkg::I2CM_IDLE)
      shift_reg <= reg_wdata[7:0];
    else if (tick && q_reg == 2'h2 && state_reg == i2cm_pkg::I2CM_RECV)
      shift_reg <= {shift_reg[6:0], sda_s2_reg};
    else if (last && state_reg == i2cm_pkg::I2CM_XMIT)
      shift_reg <= {shift_reg[6:0], 1'b1};
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      rx_data_reg <= 8'h00;
    else if (rx_done)
      rx_data_reg <= shift_reg;
  end

  // ----------------------------------------------------------------
  // control register: software sets requests, hardware clears them at sequence end or on a collision
  // ----------------------------------------------------------------
  always_comb
  begin
    req_clear = 6'h00;
    if (seq_done || coll_hit)
    begin
      case (state_reg)
        i2cm_pkg::I2CM_START: req_clear[`I2CM_CTL_START] = 1'b1;
        i2cm_pkg::I2CM_RSTART: req_clear[`I2CM_CTL_RSTART] = 1'b1;
        i2cm_pkg::I2CM_STOP: req_clear[`I2CM_CTL_STOP] = 1'b1;
        i2cm_pkg::I2CM_RECV: req_clear[`I2CM_CTL_RECV] = 1'b1;
        i2cm_pkg::I2CM_ACKSEQ: req_clear[`I2CM_CTL_ACKSEQ] = 1'b1;
        default: req_clear = 6'h00;
      endcase
    end
  end

  // a request written in the clearing cycle survives: set wins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ctrl_reg <= 6'(`I2CM_RST_WORD);
    else if (reg_wr && reg_addr == `I2CM_OFS_CONTROL)
      ctrl_reg <= {reg_wdata[`I2CM_CTL_ACKPOL], (ctrl_reg[4:0] & ~req_clear[4:0]) | reg_wdata[4:0]};
    else
      ctrl_reg <= ctrl_reg & ~req_clear;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      tx_pend_reg <= 1'b0;
    else if (reg_wr && reg_addr == `I2CM_OFS_TXDATA && state_reg == i2cm_pkg::I2CM_IDLE)
      tx_pend_reg <= 1'b1;
    else if (state_reg == i2cm_pkg::I2CM_XMIT)
      tx_pend_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // status flags
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      ack_rx_reg <= 1'b0;
    else if (tick && q_reg == 2'h2 && state_reg == i2cm_pkg::I2CM_XMIT && bit_reg == 4'h8)
      ack_rx_reg <= sda_s2_reg;
  end

  // collision flag cleared by writing 1; a new collision wins
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      coll_reg <= 1'b0;
    else if (coll_hit)
      coll_reg <= 1'b1;
    else if (reg_wr && reg_addr == `I2CM_OFS_STATUS && reg_wdata[`I2CM_ST_COLL])
      coll_reg <= 1'b0;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b0;
    end
    else if (bus_start)
    begin
      start_seen_reg <= 1'b1;
      stop_seen_reg <= 1'b0;
    end
    else if (bus_stop)
    begin
      start_seen_reg <= 1'b0;
      stop_seen_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // interrupt: sticky, write-one-to-clear, set wins
  // ----------------------------------------------------------------
  assign irq_set = {bus_stop, bus_start, coll_hit, rx_done, seq_done};

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq_stat_reg <= `I2CM_IRQ_W'(0);
    else if (reg_wr && reg_addr == `I2CM_OFS_IRQ_STAT)
      irq_stat_reg <= (irq_stat_reg & ~reg_wdata[`I2CM_IRQ_W-1:0]) | irq_set;
    else
      irq_stat_reg <= irq_stat_reg | irq_set;
  end

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      irq_mask_reg <= `I2CM_IRQ_W'(0);
    else if (reg_wr && reg_addr == `I2CM_OFS_IRQ_MASK)
      irq_mask_reg <= reg_wdata[`I2CM_IRQ_W-1:0];
  end

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ----------------------------------------------------------------
  // read port: data in the cycle after the strobe, zero otherwise
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
      reg_rdata <= `I2CM_RST_WORD;
    else if (!reg_rd)
      reg_rdata <= `I2CM_RST_WORD;
    else
    begin
      reg_rdata <= `I2CM_RST_WORD;
      case (reg_addr)
        `I2CM_OFS_CONTROL: reg_rdata[5:0] <= ctrl_reg;
        `I2CM_OFS_STATUS:
        begin
          reg_rdata[`I2CM_ST_ACKRX] <= ack_rx_reg;
          reg_rdata[`I2CM_ST_TXBUSY] <= (state_reg == i2cm_pkg::I2CM_XMIT);
          reg_rdata[`I2CM_ST_COLL] <= coll_reg;
          reg_rdata[`I2CM_ST_STOPSEEN] <= stop_seen_reg;
          reg_rdata[`I2CM_ST_STARTSEEN] <= start_seen_reg;
        end
        `I2CM_OFS_TXDATA: reg_rdata[7:0] <= shift_reg;
        `I2CM_OFS_RXDATA: reg_rdata[7:0] <= rx_data_reg;
        `I2CM_OFS_IRQ_STAT: reg_rdata[`I2CM_IRQ_W-1:0] <= irq_stat_reg;
        `I2CM_OFS_IRQ_MASK: reg_rdata[`I2CM_IRQ_W-1:0] <= irq_mask_reg;
        default: reg_rdata <= `I2CM_RST_WORD;
      endcase
    end
  end

endmodule

//--- test/i2cm_seq_assertions.sv
/*
  Concurrent checks of the two-wire master sequence controller.
  Sees only the top-level ports; bound from the bench top file.
*/
module i2cm_seq_assertions #(
  parameter int QUARTER_CYC = 250
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // register port
  input wire logic [2:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // interrupt
  input wire logic irq,
  // serial lines
  input wire logic serial_clock_line_in,
  input wire logic serial_clock_line_out,
  input wire logic serial_clock_line_oe_n,
  input wire logic serial_data_line_in,
  input wire logic serial_data_line_out,
  input wire logic serial_data_line_oe_n
);
  // ----------------------------------------------------------------
  // how long the clock pull was last left unchanged
  // ----------------------------------------------------------------
  logic scl_prev;
  int unsigned hold_cnt;

  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_prev <= 1'b1;
      hold_cnt <= 0;
    end
    else
    begin
      scl_prev <= serial_clock_line_oe_n;
      hold_cnt <= (serial_clock_line_oe_n != scl_prev) ? 0 : hold_cnt + 1;
    end
  end

  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);

  a_reset_quiet: assert property (disable iff (1'b0) !rstn |-> serial_clock_line_oe_n && serial_data_line_oe_n
    && !irq && reg_rdata == 16'h0000) else $error("outputs not quiet in reset");
  a_drive_open: assert property (serial_clock_line_out == 1'b0 && serial_data_line_out == 1'b0)
    else $error("open-drain output not low");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr[2:1] == 2'h3 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  a_request_echo: assert property (reg_wr && reg_addr == 3'h0 ##1 reg_rd && reg_addr == 3'h0 |=>
    (reg_rdata[4:0] & $past(reg_wdata[4:0], 2)) == $past(reg_wdata[4:0], 2)) else $error("request bit lost");
  a_polarity_kept: assert property (reg_wr && reg_addr == 3'h0 ##1 reg_rd && reg_addr == 3'h0 |=>
    reg_rdata[5] == $past(reg_wdata[5], 2)) else $error("ack polarity not kept");
  a_start_drives: assert property (reg_wr && reg_addr == 3'h0 && reg_wdata[0] && serial_data_line_in
    && serial_clock_line_oe_n |-> ##[1:200] !serial_data_line_oe_n) else $error("start not driven");
  a_quarter_hold: assert property ($fell(serial_clock_line_oe_n) |-> hold_cnt >= QUARTER_CYC - 1)
    else $error("clock released for less than a quarter");
  a_mask_silence: assert property (reg_wr && reg_addr == 3'h5 && reg_wdata == 16'h0000 |=> !irq)
    else $error("interrupt with all masked");
endmodule

//--- test/i2cm_target.sv
/*
  Behavioural bus target: acknowledges or not, sends one byte per frame,
  and can jam the data line. Assumes resolved lines with pull-ups.
*/
module i2cm_target (
  // resolved bus lines
  input wire logic scl,
  input wire logic sda,
  // behaviour set by the bench
  input wire logic tx_mode,
  input wire logic [7:0] tx_byte,
  input wire logic ack_en,
  input wire logic jam,
  // data pull, 1 = released
  output logic sda_rel
);
  timeunit 1ns;
  timeprecision 100ps;
  int bitn = 0;
  int slot = 9;

  // start restarts the count, stop parks the target
  always @(negedge sda) if (scl) {bitn, slot} = {32'sd0, 32'sd9};
  always @(posedge sda) if (scl) slot = 9;
  always @(posedge scl) bitn = (bitn == 8) ? 0 : bitn + 1;
  // data moves only with clock low, so it never fakes a start or stop
  always @(negedge scl) slot = bitn;
  assign sda_rel = ~jam & ((slot > 8) | (slot < 8 ? (~tx_mode | tx_byte[7 - slot])
    : (tx_mode | ~ack_en)));
endmodule

//--- test/i2cm_seq_tb.sv
/*
  Self-checking bench of the two-wire master sequence controller.
  Assumes pull-ups on both lines and a shortened quarter of 8 cycles.
*/
module i2cm_seq_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 1'b0;
  logic rstn;
  logic [2:0] reg_addr = 3'h0;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic tx_mode = 1'b0;
  logic ack_en = 1'b1;
  logic jam = 1'b0;
  logic [7:0] tx_byte = 8'hE5;
  logic [15:0] d;
  logic last_sda;
  logic [8:0] bus_bits;
  int failures = 0;
  int total_checks = 0;
  int cycles = 0;
  wire logic [15:0] reg_rdata;
  wire logic irq, scl_out, scl_oe_n, sda_out, sda_oe_n, sda_rel;
  wire logic scl = scl_oe_n | scl_out;
  wire logic sda = (sda_oe_n | sda_out) & sda_rel;

  i2cm_seq #(.QUARTER_CYC(8)) i_dut (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq), .serial_clock_line_in(scl),
    .serial_clock_line_out(scl_out), .serial_clock_line_oe_n(scl_oe_n), .serial_data_line_in(sda),
    .serial_data_line_out(sda_out), .serial_data_line_oe_n(sda_oe_n));
  i2cm_target i_tgt (.scl(scl), .sda(sda), .tx_mode(tx_mode), .tx_byte(tx_byte), .ack_en(ack_en), .jam(jam),
    .sda_rel(sda_rel));

  initial forever #5 ref_clk = ~ref_clk;
  // every bit on the bus as the clock rises, ack slots included
  always @(posedge scl)
  begin
    last_sda = sda;
    bus_bits = {bus_bits[7:0], sda};
  end

  // ----------------------------------------------------------------
  // register port tasks and checks
  // ----------------------------------------------------------------
  task automatic wr(input logic [2:0] a, input logic [15:0] v);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [2:0] a, output logic [15:0] v);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e)
    begin
      $display("Error %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask

  task automatic rdchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e, input string n);
    rd(a, d);
    chk(n, e, d & m);
  endtask

  // polls a hardware-cleared bit with a bounded number of reads
  task automatic waitclr(input logic [2:0] a, input logic [15:0] m, input string n);
    for (int i = 0; i < 2000; i++)
    begin
      rd(a, d);
      if ((d & m) === 16'h0000) break;
    end
    chk(n, 16'h0000, d & m);
  endtask

  task automatic summarize;
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      summarize;
    end
  end

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial
  begin
    // reset edge lands after every process waits, so no register starts unknown
    rstn <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'b1;
    @(posedge ref_clk);
    for (int a = 0; a < 8; a++)
      if (a != 2) rdchk(a[2:0], 16'hFFFF, 16'h0000, "reset value");
    wr(3'h0, 16'h0001);
    rdchk(3'h0, 16'h0001, 16'h0001, "start request");
    waitclr(3'h0, 16'h0001, "start clear");
    rdchk(3'h1, 16'h0018, 16'h0008, "start seen");
    // the engine leaves idle only in the cycle after the data write
    wr(3'h2, 16'h00A5);
    rd(3'h1, d);
    rdchk(3'h1, 16'h4000, 16'h4000, "tx busy");
    waitclr(3'h1, 16'h4000, "tx done");
    rdchk(3'h1, 16'h8000, 16'h0000, "ack status");
    chk("tx byte", 16'h00A5, {8'h00, bus_bits[8:1]});
    ack_en <= 1'b0;
    wr(3'h2, 16'h005A);
    rd(3'h1, d);
    rdchk(3'h1, 16'h4000, 16'h4000, "tx busy");
    waitclr(3'h1, 16'h4000, "tx done");
    rdchk(3'h1, 16'h8000, 16'h8000, "nack status");
    chk("tx byte", 16'h005A, {8'h00, bus_bits[8:1]});
    tx_mode <= 1'b1;
    wr(3'h0, 16'h0008);
    waitclr(3'h0, 16'h0008, "receive clear");
    rdchk(3'h3, 16'h00FF, 16'h00E5, "received byte");
    for (int p = 0; p < 2; p++)
    begin
      wr(3'h0, p ? 16'h0030 : 16'h0010);
      waitclr(3'h0, 16'h0010, "ack clear");
      chk("ack bit", 16'(p), {15'h0000, last_sda});
    end
    tx_mode <= 1'b0;
    wr(3'h0, 16'h0002);
    waitclr(3'h0, 16'h0002, "rstart clear");
    rdchk(3'h1, 16'h0018, 16'h0008, "rstart seen");
    wr(3'h0, 16'h0004);
    waitclr(3'h0, 16'h0004, "stop clear");
    rdchk(3'h1, 16'h0018, 16'h0010, "stop seen");
    // sequence done, byte received, start and stop seen; no collision yet
    rdchk(3'h4, 16'h001F, 16'h001B, "irq events");
    // collision: a jammed data line must abort the start
    wr(3'h4, 16'h001F);
    rdchk(3'h4, 16'h001F, 16'h0000, "irq clear");
    wr(3'h5, 16'h0004);
    jam <= 1'b1;
    wr(3'h0, 16'h0001);
    waitclr(3'h0, 16'h0001, "collision abort");
    rdchk(3'h1, 16'h0400, 16'h0400, "collision flag");
    chk("irq raised", 16'h0001, {15'h0000, irq});
    wr(3'h5, 16'h0000);
    chk("irq masked", 16'h0000, {15'h0000, irq});
    wr(3'h5, 16'h0004);
    jam <= 1'b0;
    wr(3'h1, 16'h0400);
    rdchk(3'h1, 16'h0400, 16'h0000, "collision cleared");
    wr(3'h4, 16'h0004);
    chk("irq cleared", 16'h0000, {15'h0000, irq});
    summarize;
  end
endmodule

bind i2cm_seq i2cm_seq_assertions #(.QUARTER_CYC(QUARTER_CYC)) i_chk (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
  .serial_clock_line_in(serial_clock_line_in), .serial_clock_line_out(serial_clock_line_out),
  .serial_clock_line_oe_n(serial_clock_line_oe_n), .serial_data_line_in(serial_data_line_in),
  .serial_data_line_out(serial_data_line_out), .serial_data_line_oe_n(serial_data_line_oe_n));
